//--- cifu_pkg.sv
// Register map, field layout and encodings of the codec interrupt flag unit
package cifu_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] CIFU_ADDR_CONTROL = 8'h1e;
	localparam logic [7:0] CIFU_ADDR_MASK1 = 8'h1f;
	localparam logic [7:0] CIFU_ADDR_MASK2 = 8'h20;
	localparam logic [7:0] CIFU_ADDR_FLAGS1 = 8'h21;
	localparam logic [7:0] CIFU_ADDR_FLAGS2 = 8'h22;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CIFU_CTL_MODE_BIT = 7;
	localparam int CIFU_CTL_STYLE_HI = 6;
	localparam int CIFU_CTL_STYLE_LO = 5;
	localparam logic [7:0] CIFU_CTL_USED = 8'he0;
	localparam logic [7:0] CIFU_CTL_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Mask and flag register fields
	// ----------------------------------------------------------------
	localparam int CIFU_BIT_TEST = 7;
	localparam int CIFU_BIT_SERIAL = 6;
	localparam int CIFU_BIT_CLOCK = 5;
	localparam int CIFU_BIT_ADC_LO = 0;
	localparam logic [7:0] CIFU_REG1_USED = 8'hef;
	localparam logic [7:0] CIFU_REG2_USED = 8'h1f;
	localparam int CIFU_BIT_DAC_LO = 0;
	localparam logic [7:0] CIFU_MASK_RESET = 8'hff;
	localparam logic [7:0] CIFU_ZERO = 8'h00;
	localparam logic [7:0] CIFU_ALL = 8'hff;

	// ----------------------------------------------------------------
	// Interrupt pin style
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CIFU_STYLE_HIGH = 2'h0,
		CIFU_STYLE_LOW = 2'h1,
		CIFU_STYLE_DRAIN = 2'h2,
		CIFU_STYLE_RSVD = 2'h3
	} cifu_style_e;

	localparam logic CIFU_MODE_AUTO = 1'b0;

endpackage : cifu_pkg

//--- cifu_irq_unit.sv
// Interrupt flag unit: sticky error flags, masks and the interrupt pin
// What this block does
// [RULE1] Mode bit 0: reading a set flag sets its matching mask bit.
// [RULE2] Mode bit 1: reads leave masks alone; only writes change them.
// [RULE3] Pin style 00 active high, 01 active low, 10 open-drain low.
// [RULE4] Control register: mode bit 7, pin style bits 6..5, rest reserved.
// [RULE5] Test mode entry by a control write raises the test error.
// [RULE6] Format or speed change while powered up raises serial port error.
// [RULE7] Clock ratio change while powered up raises serial and clock errors.
// [RULE8] First mask: test 7, serial 6, clock 5, ADC overflow 3..0.
// [RULE9] Mask bit 0 lets the event drive the pin, 1 blocks it.
// [RULE10] Second mask holds DAC clip masks in bits 4..0.
// [RULE11] First flag register read-only, same layout as first mask.
// [RULE12] Second flag register read-only, DAC clip flags bits 4..0.
// [RULE13] Each flag is sticky until cleared.
// [RULE14] Reading a flag register clears it; events during the read survive.
// [RULE15] Pin asserted while any unmasked flag is set.
`timescale 1ns/1ps
`default_nettype none

module cifu_irq_unit
	import cifu_pkg::*;
#(
	parameter int ADC_CHANNELS = 4,
	parameter int DAC_CHANNELS = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port from the control port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Event sources
	input wire logic test_entry_write,
	input wire logic ratio_change,
	input wire logic [ADC_CHANNELS-1:0] adc_overflow_flag,
	input wire logic [DAC_CHANNELS-1:0] dac_clipping_flag,
	// Configuration watched for serial port errors
	input wire logic [1:0] serial_frame_format,
	input wire logic [1:0] speed_mode,
	input wire logic [ADC_CHANNELS-1:0] adc_powerdown_bit,
	input wire logic [DAC_CHANNELS-1:0] dac_powerdown_bit,
	// Interrupt pin
	output logic irq_pin_out,
	output logic irq_pin_oe_n
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (ADC_CHANNELS < 1 || ADC_CHANNELS > 4 || DAC_CHANNELS < 1 || DAC_CHANNELS > 5) begin : g_chk
		$error("cifu_irq_unit: channel counts out of range");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] ctl_reg;
	logic [7:0] mask1_reg;
	logic [7:0] mask2_reg;
	logic [7:0] flags1_reg;
	logic [7:0] flags2_reg;
	logic [7:0] rdata_reg;
	logic pin_reg;
	logic oe_n_reg;
	logic [1:0] fmt_prev_reg;
	logic [1:0] speed_prev_reg;
	logic primed_reg;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire logic wr_ctl = reg_wr && (reg_addr == CIFU_ADDR_CONTROL);
	wire logic wr_mask1 = reg_wr && (reg_addr == CIFU_ADDR_MASK1);
	wire logic wr_mask2 = reg_wr && (reg_addr == CIFU_ADDR_MASK2);
	wire logic rd_flags1 = reg_rd && (reg_addr == CIFU_ADDR_FLAGS1);
	wire logic rd_flags2 = reg_rd && (reg_addr == CIFU_ADDR_FLAGS2);
	wire logic auto_mode = (ctl_reg[CIFU_CTL_MODE_BIT] == CIFU_MODE_AUTO);
	wire cifu_style_e style = cifu_style_e'(ctl_reg[CIFU_CTL_STYLE_HI:CIFU_CTL_STYLE_LO]);

	// ----------------------------------------------------------------
	// Event detection
	// ----------------------------------------------------------------
	wire logic powered_down = (&adc_powerdown_bit) && (&dac_powerdown_bit);
	wire logic cfg_change = primed_reg && ((serial_frame_format != fmt_prev_reg) ||
		(speed_mode != speed_prev_reg));
	wire logic ratio_fault = ratio_change && !powered_down; // RULE7
	wire logic serial_fault = (cfg_change && !powered_down) || ratio_fault; // RULE6 RULE7

	logic [7:0] ev1;
	logic [7:0] ev2;
	always_comb begin
		ev1 = CIFU_ZERO;
		ev2 = CIFU_ZERO;
		ev1[CIFU_BIT_TEST] = test_entry_write; // RULE5
		ev1[CIFU_BIT_SERIAL] = serial_fault; // RULE6
		ev1[CIFU_BIT_CLOCK] = ratio_fault; // RULE7
		ev1[CIFU_BIT_ADC_LO +: ADC_CHANNELS] = adc_overflow_flag; // RULE11
		ev2[CIFU_BIT_DAC_LO +: DAC_CHANNELS] = dac_clipping_flag; // RULE12
	end

	// ----------------------------------------------------------------
	// Flags: set wins over read clear
	// ----------------------------------------------------------------
	wire logic [7:0] clr1 = rd_flags1 ? CIFU_ALL : CIFU_ZERO;
	wire logic [7:0] clr2 = rd_flags2 ? CIFU_ALL : CIFU_ZERO;
	wire logic [7:0] flags1_next = ((flags1_reg & ~clr1) | ev1) & CIFU_REG1_USED; // RULE13 RULE14
	wire logic [7:0] flags2_next = ((flags2_reg & ~clr2) | ev2) & CIFU_REG2_USED; // RULE13 RULE14

	// ----------------------------------------------------------------
	// Masks: write, or auto-set on read in mode 0
	// ----------------------------------------------------------------
	wire logic [7:0] auto1 = (rd_flags1 && auto_mode) ? flags1_reg : CIFU_ZERO; // RULE1 RULE2
	wire logic [7:0] auto2 = (rd_flags2 && auto_mode) ? flags2_reg : CIFU_ZERO; // RULE1 RULE2
	wire logic [7:0] mask1_next = wr_mask1 ? (reg_wdata & CIFU_REG1_USED) :
		(mask1_reg | auto1); // RULE8
	wire logic [7:0] mask2_next = wr_mask2 ? (reg_wdata & CIFU_REG2_USED) :
		(mask2_reg | auto2); // RULE10
	wire logic [7:0] ctl_next = wr_ctl ? (reg_wdata & CIFU_CTL_USED) : ctl_reg; // RULE4

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	wire logic raise = |((flags1_next & ~mask1_next) | (flags2_next & ~mask2_next)); // RULE9 RULE15
	wire cifu_style_e style_next = cifu_style_e'(ctl_next[CIFU_CTL_STYLE_HI:CIFU_CTL_STYLE_LO]);
	wire logic low_active = (style_next == CIFU_STYLE_LOW) || (style_next == CIFU_STYLE_DRAIN);
	wire logic pin_next = low_active ? !raise : raise; // RULE3
	wire logic oe_n_next = (style_next == CIFU_STYLE_DRAIN) && !raise; // RULE3

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	wire logic [7:0] rd_mux =
		(reg_addr == CIFU_ADDR_CONTROL) ? ctl_reg :
		(reg_addr == CIFU_ADDR_MASK1) ? mask1_reg :
		(reg_addr == CIFU_ADDR_MASK2) ? mask2_reg :
		(reg_addr == CIFU_ADDR_FLAGS1) ? flags1_reg :
		(reg_addr == CIFU_ADDR_FLAGS2) ? flags2_reg : CIFU_ZERO;
	wire logic [7:0] rdata_next = reg_rd ? rd_mux : rdata_reg;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctl_reg <= CIFU_CTL_RESET;
			mask1_reg <= CIFU_MASK_RESET & CIFU_REG1_USED;
			mask2_reg <= CIFU_MASK_RESET & CIFU_REG2_USED;
			flags1_reg <= CIFU_ZERO;
			flags2_reg <= CIFU_ZERO;
			rdata_reg <= CIFU_ZERO;
		end else begin
			ctl_reg <= ctl_next;
			mask1_reg <= mask1_next;
			mask2_reg <= mask2_next;
			flags1_reg <= flags1_next;
			flags2_reg <= flags2_next;
			rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_reg <= 1'b0;
			oe_n_reg <= 1'b0;
			fmt_prev_reg <= 2'h0;
			speed_prev_reg <= 2'h0;
			primed_reg <= 1'b0;
		end else begin
			pin_reg <= pin_next;
			oe_n_reg <= oe_n_next;
			fmt_prev_reg <= serial_frame_format;
			speed_prev_reg <= speed_mode;
			primed_reg <= 1'b1;
		end
	end

	assign reg_rdata = rdata_reg;
	assign irq_pin_out = pin_reg;
	assign irq_pin_oe_n = oe_n_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_read1_auto;
		rd_flags1 && auto_mode && !wr_mask1;
	endsequence

	sequence s_read1_manual;
		rd_flags1 && !auto_mode && !wr_mask1;
	endsequence

	sequence s_read2_auto;
		rd_flags2 && auto_mode && !wr_mask2;
	endsequence

	sequence s_read2_manual;
		rd_flags2 && !auto_mode && !wr_mask2;
	endsequence

	a_auto_mask_set: assert property (s_read1_auto |=> // RULE1
		((mask1_reg & $past(flags1_reg)) == $past(flags1_reg)))
		else $error("flag read in mode 0 did not set mask");

	a_manual_mask_hold: assert property (s_read1_manual |=> // RULE2
		(mask1_reg == $past(mask1_reg)))
		else $error("flag read in mode 1 changed mask");

	a_style_high_drive: assert property ((style == CIFU_STYLE_HIGH) && !wr_ctl ##1 // RULE3
		(style == CIFU_STYLE_HIGH) |-> (irq_pin_out == (|((flags1_reg & ~mask1_reg) |
		(flags2_reg & ~mask2_reg)))) && !irq_pin_oe_n)
		else $error("active high pin wrong");

	a_drain_release: assert property ((style == CIFU_STYLE_DRAIN) && !raise && !wr_ctl // RULE3
		|=> irq_pin_oe_n)
		else $error("open drain pin not released");

	a_ctl_reserved_zero: assert property ((ctl_reg & ~CIFU_CTL_USED) == CIFU_ZERO) // RULE4
		else $error("control reserved bits set");

	a_test_entry_flag: assert property (test_entry_write |=> flags1_reg[CIFU_BIT_TEST]) // RULE5
		else $error("test entry not flagged");

	a_serial_on_change: assert property (cfg_change && !powered_down // RULE6
		|=> flags1_reg[CIFU_BIT_SERIAL])
		else $error("serial port error missed");

	a_ratio_both: assert property (ratio_change && !powered_down |=> // RULE7
		flags1_reg[CIFU_BIT_SERIAL] && flags1_reg[CIFU_BIT_CLOCK])
		else $error("ratio change not flagged twice");

	a_mask_blocks_pin: assert property (style == CIFU_STYLE_HIGH && !wr_ctl // RULE9
		&& (flags1_next & ~mask1_next) == CIFU_ZERO && (flags2_next & ~mask2_next) == CIFU_ZERO
		|=> !irq_pin_out)
		else $error("masked flags drove pin");

	a_flag_sticky: assert property (flags2_reg[CIFU_BIT_DAC_LO] && !rd_flags2 // RULE13
		|=> flags2_reg[CIFU_BIT_DAC_LO])
		else $error("flag lost without read");

	a_read_clears: assert property (rd_flags1 && ev1 == CIFU_ZERO |=> // RULE14
		flags1_reg == CIFU_ZERO)
		else $error("read did not clear flags");

	a_auto_mask2_set: assert property (s_read2_auto |=> // RULE1
		((mask2_reg & $past(flags2_reg)) == $past(flags2_reg)))
		else $error("flag read in mode 0 did not set second mask");

	a_manual_mask2_hold: assert property (s_read2_manual |=> // RULE2
		(mask2_reg == $past(mask2_reg)))
		else $error("flag read in mode 1 changed second mask");

	a_ctl_write_lands: assert property (wr_ctl |=> // RULE4
		(ctl_reg == ($past(reg_wdata) & CIFU_CTL_USED)))
		else $error("control write did not land");

	a_mask1_write_lands: assert property (wr_mask1 |=> // RULE8
		(mask1_reg == ($past(reg_wdata) & CIFU_REG1_USED)))
		else $error("first mask write did not land");

	a_mask2_write_lands: assert property (wr_mask2 |=> // RULE10
		(mask2_reg == ($past(reg_wdata) & CIFU_REG2_USED)))
		else $error("second mask write did not land");

	a_style_low_drive: assert property ((style_next == CIFU_STYLE_LOW) |=> // RULE3
		(irq_pin_out == !$past(raise)) && !irq_pin_oe_n)
		else $error("active low pin wrong");

	a_drain_pull: assert property ((style_next == CIFU_STYLE_DRAIN) && raise |=> // RULE3
		!irq_pin_out && !irq_pin_oe_n)
		else $error("open drain pin not pulled low");

	a_unmasked_raises: assert property ((style_next == CIFU_STYLE_HIGH) && // RULE15
		((flags1_next & ~mask1_next) != CIFU_ZERO) |=> irq_pin_out)
		else $error("unmasked flag did not raise pin");

	a_flag1_read_data: assert property (rd_flags1 |=> // RULE11
		(reg_rdata == $past(flags1_reg)))
		else $error("first flag read returned wrong data");

	a_flag2_read_data: assert property (rd_flags2 |=> // RULE12
		(reg_rdata == $past(flags2_reg)))
		else $error("second flag read returned wrong data");

	a_flags_read_only: assert property (reg_wr && !reg_rd && ev1 == CIFU_ZERO |=> // RULE11
		(flags1_reg == $past(flags1_reg)))
		else $error("write changed flag register");

	a_serial_quiet: assert property (!flags1_reg[CIFU_BIT_SERIAL] && !serial_fault |=> // RULE6
		!flags1_reg[CIFU_BIT_SERIAL])
		else $error("serial port error without cause");

	a_down_quiet: assert property (!flags1_reg[CIFU_BIT_CLOCK] && powered_down |=> // RULE7
		!flags1_reg[CIFU_BIT_CLOCK])
		else $error("clock error while powered down");

	a_test_flag_sticky: assert property (flags1_reg[CIFU_BIT_TEST] && !rd_flags1 |=> // RULE13
		flags1_reg[CIFU_BIT_TEST])
		else $error("test error flag lost without read");

	a_event_kept: assert property (rd_flags2 && dac_clipping_flag[0] // RULE14
		|=> flags2_reg[CIFU_BIT_DAC_LO])
		else $error("event during read lost");

endmodule : cifu_irq_unit

`default_nettype wire

//--- cifu_host.sv
// Host controller model driving the register port of the interrupt flag unit
`timescale 1ns/1ps
`default_nettype none

module cifu_host (
	// Clock
	input wire logic clk,
	// Register port
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end

	// ----------------------------------------------------------------
	// Bus cycles
	// ----------------------------------------------------------------
	// Released address and data are inverted so stale values never match
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr

	// Data is taken after a full cycle, as it holds until the next read
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk);
		#1;
		d = reg_rdata;
	endtask : rd
endmodule : cifu_host

`default_nettype wire

//--- codec_interrupt_flag_unit_tb.sv
// Self-checking testbench for the codec interrupt flag unit
`timescale 1ns/1ps
`default_nettype none

module codec_interrupt_flag_unit_tb
	import cifu_pkg::*;
;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} cifu_row_s;
	logic clk, sys_rst, reg_wr, reg_rd, test_w, ratio, pin_out, oe_n;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
	logic [3:0] adc, adc_pd;
	logic [4:0] dac, dac_pd;
	logic [1:0] fmt, spd;
	int mismatches, checks_done;
	cifu_row_s rows [6] = '{'{CIFU_ADDR_CONTROL, 8'h9f, 8'h80}, '{CIFU_ADDR_MASK1, 8'h10, 8'h00},
		'{CIFU_ADDR_MASK2, 8'hff, 8'h1f}, '{CIFU_ADDR_FLAGS1, 8'hff, 8'h00},
		'{CIFU_ADDR_FLAGS2, 8'hff, 8'h00}, '{8'h23, 8'hff, 8'h00}};

	cifu_irq_unit i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .test_entry_write(test_w),
		.ratio_change(ratio), .adc_overflow_flag(adc), .dac_clipping_flag(dac),
		.serial_frame_format(fmt), .speed_mode(spd), .adc_powerdown_bit(adc_pd),
		.dac_powerdown_bit(dac_pd), .irq_pin_out(pin_out), .irq_pin_oe_n(oe_n));
	cifu_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk

	// One-cycle event pulse, then time for the pin to follow
	task automatic ev(input logic t, input logic r, input logic [3:0] a, input logic [4:0] d);
		@(posedge clk);
		test_w <= t;
		ratio <= r;
		adc <= a;
		dac <= d;
		@(posedge clk);
		test_w <= 1'b0;
		ratio <= 1'b0;
		adc <= 4'h0;
		dac <= 5'h00;
		repeat (2) @(posedge clk);
		#1;
	endtask : ev

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#100us;
		mismatches++;
		conclude();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{sys_rst, test_w, ratio, adc, dac, fmt, spd, adc_pd, dac_pd} = {1'b1, 24'h0};
		mismatches = 0;
		checks_done = 0;
		repeat (8) @(posedge clk);
		chk("pin in reset", {6'h0, pin_out, oe_n}, 8'h00);
		sys_rst <= 1'b0;
		i_host.rd(CIFU_ADDR_CONTROL, v);
		chk("ctl reset", v, CIFU_CTL_RESET);
		i_host.rd(CIFU_ADDR_MASK1, v);
		chk("mask1 reset", v, CIFU_MASK_RESET & CIFU_REG1_USED);
		foreach (rows[i]) begin
			i_host.wr(rows[i].a, rows[i].d);
			i_host.rd(rows[i].a, v);
			chk("table", v, rows[i].e);
		end
		ev(1'b0, 1'b0, 4'h4, 5'h00);
		chk("pin raised", {7'h0, pin_out}, 8'h01);
		i_host.rd(CIFU_ADDR_FLAGS1, v);
		chk("flags1 adc", v, 8'h04);
		i_host.rd(CIFU_ADDR_FLAGS1, v);
		chk("flags1 cleared", v, 8'h00);
		i_host.rd(CIFU_ADDR_MASK1, v);
		chk("mask1 kept", v, 8'h00);
		chk("pin dropped", {7'h0, pin_out}, 8'h00);
		ev(1'b0, 1'b0, 4'h0, 5'h10);
		chk("pin masked", {7'h0, pin_out}, 8'h00);
		i_host.rd(CIFU_ADDR_FLAGS2, v);
		chk("flags2 clip", v, 8'h10);
		fork
			i_host.rd(CIFU_ADDR_FLAGS1, v);
			ev(1'b0, 1'b0, 4'h2, 5'h00);
		join
		i_host.rd(CIFU_ADDR_FLAGS1, v);
		chk("event during read", v, 8'h02);
		i_host.wr(CIFU_ADDR_CONTROL, 8'h00);
		ev(1'b1, 1'b0, 4'h0, 5'h00);
		i_host.rd(CIFU_ADDR_FLAGS1, v);
		chk("test error", v, 8'h80);
		i_host.rd(CIFU_ADDR_MASK1, v);
		chk("auto mask", v, 8'h80);
		@(posedge clk) fmt <= 2'h1;
		i_host.rd(CIFU_ADDR_FLAGS1, v);
		chk("format change", v, 8'h40);
		@(posedge clk) {adc_pd, dac_pd} <= 9'h1ff;
		@(posedge clk) spd <= 2'h1;
		ev(1'b0, 1'b1, 4'h0, 5'h00);
		i_host.rd(CIFU_ADDR_FLAGS1, v);
		chk("powered down", v, 8'h00);
		@(posedge clk) {adc_pd, dac_pd} <= 9'h000;
		ev(1'b0, 1'b1, 4'h0, 5'h00);
		i_host.rd(CIFU_ADDR_FLAGS1, v);
		chk("ratio change", v, 8'h60);
		i_host.wr(CIFU_ADDR_MASK1, 8'h00);
		for (int s = 0; s < 3; s++) begin
			i_host.wr(CIFU_ADDR_CONTROL, {1'b1, s[1:0], 5'h00});
			repeat (2) @(posedge clk);
			#1;
			chk("oe idle", {7'h0, oe_n}, {7'h0, s == 2});
			if (s != 2) chk("pin idle", {7'h0, pin_out}, {7'h0, s == 1});
			ev(1'b0, 1'b0, 4'h1, 5'h00);
			chk("pin busy", {6'h0, pin_out, oe_n}, {6'h0, s == 0, 1'b0});
			i_host.rd(CIFU_ADDR_FLAGS1, v);
		end
		ev(1'b0, 1'b0, 4'h0, 5'h01);
		chk("drain masked", {6'h0, pin_out, oe_n}, 8'h03);
		@(posedge clk) spd <= 2'h2;
		i_host.rd(CIFU_ADDR_FLAGS1, v);
		chk("speed change", v, 8'h40);
		i_host.wr(CIFU_ADDR_CONTROL, 8'h00);
		i_host.wr(CIFU_ADDR_MASK2, 8'h00);
		@(posedge clk);
		#1;
		chk("clip unmasked", {7'h0, pin_out}, 8'h01);
		i_host.rd(CIFU_ADDR_FLAGS2, v);
		chk("flags2 auto", v, 8'h01);
		i_host.rd(CIFU_ADDR_MASK2, v);
		chk("auto mask2", v, 8'h01);
		ev(1'b0, 1'b0, 4'h8, 5'h00);
		chk("pin before reset", {7'h0, pin_out}, 8'h01);
		// Mid-run reset: pin drops, no false format event after release
		@(posedge clk) sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("pin mid reset", {6'h0, pin_out, oe_n}, 8'h00);
		@(posedge clk) sys_rst <= 1'b0;
		i_host.rd(CIFU_ADDR_MASK2, v);
		chk("mask2 after reset", v, CIFU_MASK_RESET & CIFU_REG2_USED);
		i_host.rd(CIFU_ADDR_FLAGS1, v);
		chk("flags1 after reset", v, CIFU_ZERO);
		conclude();
	end
endmodule : codec_interrupt_flag_unit_tb

`default_nettype wire
